// ---- hdl/bus_cmd_consts.vh ----
// Constants of the bus command controller: offsets, field positions, reset values, timing.
// Assumes a 100 MHz pclk and a 32-bit APB register port.
// Contract
// - Top bit low: acknowledge, I/O read, I/O writes, halt
// - Top bit high: memory reads, memory writes, passive
// - Undriven status inputs read high, decode passive
// - Six command strobes and acknowledge active low
// - I/O mode: I/O strobes ignore arbitration enable
// - I/O mode: I/O commands immediate, peripheral enable
// - I/O mode: memory commands still await arbitration
// - System mode: all commands wait enable delay
// - Early writes asserted with read-strobe timing
// - Acknowledge strobe timed like an I/O read
// - Active-high data enable plus direction output
// - I/O mode: shared pin is peripheral data enable
// - System mode: shared pin is cascade enable
// - Address latch strobe pulses every machine cycle
// - Address latch strobe captures status for halt
// - Disqualified commands driven inactive, not floated
// - Low qualifier forces commands and enables inactive
// - Direction high for writes, low for reads
// - Arbitration loss floats arbitrated command drivers
// - Address latch strobe active high
`ifndef BUS_CMD_CONSTS_VH
`define BUS_CMD_CONSTS_VH

`define STATUS_PASSIVE      3'h7
`define STATUS_INTERRUPT_ACKNOWLEDGE_STROBE         3'h0
`define STATUS_IO_READ      3'h1
`define STATUS_IO_WRITE     3'h2
`define STATUS_HALT         3'h3
`define STATUS_CODE_FETCH   3'h4
`define STATUS_MEM_READ     3'h5
`define STATUS_MEM_WRITE    3'h6

`define CMD_MEM_READ        0
`define CMD_MEM_WRITE       1
`define CMD_IO_READ         2
`define CMD_IO_WRITE        3
`define CMD_EARLY_MEM_WRITE 4
`define CMD_EARLY_IO_WRITE  5
`define CMD_INTERRUPT_ACKNOWLEDGE_STROBE            6
`define CMD_WIDTH           7

`define CLK_PERIOD_NS       10
`define ENABLE_DELAY_NS     110
`define ENABLE_DELAY_CYCLES ((`ENABLE_DELAY_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`define ADDR_CONTROL        12'h000
`define ADDR_STATUS         12'h004
`define ADDR_CYCLE_COUNT    12'h008

`define CTRL_SOFT_ENABLE    0
`define CTRL_RESET          1'h1

`define STAT_LATCH_LSB      0
`define STAT_MODE           3
`define STAT_GATE_OPEN      4
`define STAT_HALTED         5
`define STAT_CMD_LSB        8

`endif

// ---- hdl/two_flop_sync.v ----
// Two-flop synchroniser for a vector of independent level inputs.
// Assumes each bit is a slow level; no bus coherency between bits.
`timescale 1ns/1ps
`default_nettype none
module two_flop_sync #(
  parameter WIDTH     = 1,
  parameter RESET_VAL = 0
) (
  input  wire             pclk,
  input  wire             presetn,
  input  wire [WIDTH-1:0] async_in,
  output wire [WIDTH-1:0] sync_out
);
  reg [WIDTH-1:0] stage1_reg;
  reg [WIDTH-1:0] stage2_reg;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stage1_reg <= RESET_VAL[WIDTH-1:0];
      stage2_reg <= RESET_VAL[WIDTH-1:0];
    end else begin
      stage1_reg <= async_in;
      stage2_reg <= stage1_reg;
    end
  end

  assign sync_out = stage2_reg;
endmodule
`default_nettype wire

// ---- hdl/cpu_bus_command_controller.v ----
// Bus command controller: status decode to command strobes, latch strobe, transceiver control.
// Assumes status, arbitration, qualifier and strap arrive asynchronously on pins; APB on pclk.
//
// Local design decisions: the APB register port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
`include "bus_cmd_consts.vh"
module cpu_bus_command_controller (
  input  wire        pclk,
  input  wire        presetn,
  input  wire [2:0]  processor_status_inputs,
  input  wire [2:0]  processor_status_driven,
  input  wire        arbitration_enable_n,
  input  wire        command_qualifier,
  input  wire        bus_mode_strap,
  output reg         memory_read_strobe_n,
  output reg         memory_read_strobe_oe,
  output reg         memory_write_strobe_n,
  output reg         memory_write_strobe_oe,
  output reg         early_memory_write_strobe_n,
  output reg         early_memory_write_strobe_oe,
  output reg         io_read_strobe_n,
  output reg         io_read_strobe_oe,
  output reg         io_write_strobe_n,
  output reg         io_write_strobe_oe,
  output reg         early_io_write_strobe_n,
  output reg         early_io_write_strobe_oe,
  output reg         interrupt_acknowledge_strobe_n,
  output reg         interrupt_acknowledge_strobe_oe,
  output reg         address_latch_strobe,
  output reg         transceiver_enable,
  output reg         transfer_direction,
  output reg         cascade_or_peripheral_enable,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr
);
  localparam [3:0] ST_IDLE  = 4'h1;
  localparam [3:0] ST_ADDR  = 4'h2;
  localparam [3:0] ST_EARLY = 4'h4;
  localparam [3:0] ST_FULL  = 4'h8;
  // Enable delay rounded up to whole clocks
  localparam integer ARB_CYCLES_INT = `ENABLE_DELAY_CYCLES;
  localparam [3:0]   ARB_CYCLES     = ARB_CYCLES_INT[3:0];

  // Status code to active-high command vector
  function [`CMD_WIDTH-1:0] decode_status;
    input [2:0] code;
    begin
      decode_status = {`CMD_WIDTH{1'b0}};
      case (code)
        `STATUS_INTERRUPT_ACKNOWLEDGE_STROBE:       decode_status[`CMD_INTERRUPT_ACKNOWLEDGE_STROBE] = 1'b1;
        `STATUS_IO_READ:    decode_status[`CMD_IO_READ] = 1'b1;
        `STATUS_IO_WRITE: begin
          decode_status[`CMD_IO_WRITE] = 1'b1;
          decode_status[`CMD_EARLY_IO_WRITE] = 1'b1;
        end
        `STATUS_CODE_FETCH: decode_status[`CMD_MEM_READ] = 1'b1;
        `STATUS_MEM_READ:   decode_status[`CMD_MEM_READ] = 1'b1;
        `STATUS_MEM_WRITE: begin
          decode_status[`CMD_MEM_WRITE] = 1'b1;
          decode_status[`CMD_EARLY_MEM_WRITE] = 1'b1;
        end
        default:            decode_status = {`CMD_WIDTH{1'b0}};
      endcase
    end
  endfunction

  wire [2:0] status_pin;
  wire [2:0] status_sync;
  wire       aen_n_sync;
  wire       qual_sync;
  wire       strap_sync;

  assign status_pin = processor_status_inputs | ~processor_status_driven;

  // Bits synchronise independently; codes must settle
  two_flop_sync #(
    .WIDTH     (6),
    .RESET_VAL (6'h3f)
  ) u_sync (
    .pclk     (pclk),
    .presetn  (presetn),
    .async_in ({status_pin, arbitration_enable_n, command_qualifier, bus_mode_strap}),
    .sync_out ({status_sync, aen_n_sync, qual_sync, strap_sync})
  );

  reg  [3:0]  state_reg;
  reg  [3:0]  state_next;
  reg  [2:0]  status_prev_reg;
  reg  [2:0]  halt_latch_reg;
  reg  [2:0]  halt_latch_next;
  reg  [3:0]  arb_cnt_reg;
  reg  [1:0]  strap_cnt_reg;
  reg         io_mode_reg;
  reg         soft_enable_reg;
  reg  [15:0] cycle_count_reg;

  // New cycle only after a passive gap
  wire cycle_start = (status_prev_reg == `STATUS_PASSIVE) && (status_sync != `STATUS_PASSIVE);
  wire passive_now = (status_sync == `STATUS_PASSIVE);
  wire arb_open    = (arb_cnt_reg == ARB_CYCLES);
  wire cmd_allowed = qual_sync & soft_enable_reg;

  // Strap caught a few cycles after reset release
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      strap_cnt_reg <= 2'h0;
      io_mode_reg   <= 1'b0;
    end else if (strap_cnt_reg != 2'h3) begin
      strap_cnt_reg <= strap_cnt_reg + 2'h1;
      // Sampled once; later strap changes ignored
      if (strap_cnt_reg == 2'h2) begin
        io_mode_reg <= strap_sync;
      end
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      arb_cnt_reg <= 4'h0;
    end else if (aen_n_sync) begin
      arb_cnt_reg <= 4'h0;
    end else if (!arb_open) begin
      arb_cnt_reg <= arb_cnt_reg + 4'h1;
    end
  end

  always @* begin
    state_next = state_reg;
    halt_latch_next = halt_latch_reg;
    case (state_reg)
      ST_IDLE: begin
        if (cycle_start) begin
          state_next = ST_ADDR;
          halt_latch_next = status_sync;
        end
      end
      ST_ADDR: begin
        state_next = passive_now ? ST_IDLE : ST_EARLY;
      end
      ST_EARLY: begin
        state_next = passive_now ? ST_IDLE : ST_FULL;
      end
      ST_FULL: begin
        if (passive_now) begin
          state_next = ST_IDLE;
        end
      end
      default: begin
        state_next = ST_IDLE;
      end
    endcase
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg       <= ST_IDLE;
      status_prev_reg <= `STATUS_PASSIVE;
      halt_latch_reg  <= `STATUS_PASSIVE;
      cycle_count_reg <= 16'h0000;
    end else begin
      state_reg       <= state_next;
      status_prev_reg <= status_sync;
      halt_latch_reg  <= halt_latch_next;
      if (state_reg == ST_IDLE && cycle_start) begin
        cycle_count_reg <= cycle_count_reg + 16'h0001;
      end
    end
  end

  // Command generation from the next state and latched code
  wire [`CMD_WIDTH-1:0] cyc_cmd = decode_status(halt_latch_next);
  wire                  in_early = (state_next == ST_EARLY) || (state_next == ST_FULL);
  wire                  in_full  = (state_next == ST_FULL);
  wire                  io_cycle = cyc_cmd[`CMD_IO_READ] | cyc_cmd[`CMD_IO_WRITE] | cyc_cmd[`CMD_INTERRUPT_ACKNOWLEDGE_STROBE];
  wire                  mem_cycle = cyc_cmd[`CMD_MEM_READ] | cyc_cmd[`CMD_MEM_WRITE];
  wire                  write_cycle = cyc_cmd[`CMD_MEM_WRITE] | cyc_cmd[`CMD_IO_WRITE];

  // I/O strobes ignore arbitration in I/O mode
  wire io_gate  = io_mode_reg | arb_open;
  wire mem_gate = arb_open;
  // Memory drivers, and I/O drivers in system mode, float once the grant loss is synchronised
  // arbitration loss floats arbitrated drivers
  wire io_oe    = io_mode_reg | ~aen_n_sync;
  wire mem_oe   = ~aen_n_sync;

  reg [`CMD_WIDTH-1:0] cmd_active;
  always @* begin
    cmd_active = {`CMD_WIDTH{1'b0}};
    cmd_active[`CMD_MEM_READ]        = in_early & cyc_cmd[`CMD_MEM_READ] & mem_gate;
    cmd_active[`CMD_EARLY_MEM_WRITE] = in_early & cyc_cmd[`CMD_EARLY_MEM_WRITE] & mem_gate;
    cmd_active[`CMD_MEM_WRITE]       = in_full & cyc_cmd[`CMD_MEM_WRITE] & mem_gate;
    // I/O commands without waiting in I/O mode
    cmd_active[`CMD_IO_READ]         = in_early & cyc_cmd[`CMD_IO_READ] & io_gate;
    cmd_active[`CMD_EARLY_IO_WRITE]  = in_early & cyc_cmd[`CMD_EARLY_IO_WRITE] & io_gate;
    cmd_active[`CMD_IO_WRITE]        = in_full & cyc_cmd[`CMD_IO_WRITE] & io_gate;
    cmd_active[`CMD_INTERRUPT_ACKNOWLEDGE_STROBE]            = in_early & cyc_cmd[`CMD_INTERRUPT_ACKNOWLEDGE_STROBE] & io_gate;
    if (!cmd_allowed) begin
      cmd_active = {`CMD_WIDTH{1'b0}};
    end
  end

  // I/O mode: I/O cycles use the shared pin instead
  wire den_next  = cmd_allowed & in_early & (io_mode_reg ? (mem_cycle & mem_gate) :
                                                          ((mem_cycle & mem_gate) | (io_cycle & io_gate)));
  wire peripheral_data_enable_next = cmd_allowed & in_early & io_cycle;
  // Cascade pulse rides with the latch strobe
  wire mce_next  = cmd_allowed & (state_next == ST_ADDR) & cyc_cmd[`CMD_INTERRUPT_ACKNOWLEDGE_STROBE];

  // Command strobes
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      memory_read_strobe_n            <= 1'b1;
      memory_write_strobe_n           <= 1'b1;
      early_memory_write_strobe_n     <= 1'b1;
      io_read_strobe_n                <= 1'b1;
      io_write_strobe_n               <= 1'b1;
      early_io_write_strobe_n         <= 1'b1;
      interrupt_acknowledge_strobe_n  <= 1'b1;
    end else begin
      memory_read_strobe_n            <= ~cmd_active[`CMD_MEM_READ];
      memory_write_strobe_n           <= ~cmd_active[`CMD_MEM_WRITE];
      early_memory_write_strobe_n     <= ~cmd_active[`CMD_EARLY_MEM_WRITE];
      io_read_strobe_n                <= ~cmd_active[`CMD_IO_READ];
      io_write_strobe_n               <= ~cmd_active[`CMD_IO_WRITE];
      early_io_write_strobe_n         <= ~cmd_active[`CMD_EARLY_IO_WRITE];
      interrupt_acknowledge_strobe_n  <= ~cmd_active[`CMD_INTERRUPT_ACKNOWLEDGE_STROBE];
    end
  end

  // Driver enables
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      memory_read_strobe_oe           <= 1'b0;
      memory_write_strobe_oe          <= 1'b0;
      early_memory_write_strobe_oe    <= 1'b0;
      io_read_strobe_oe               <= 1'b0;
      io_write_strobe_oe              <= 1'b0;
      early_io_write_strobe_oe        <= 1'b0;
      interrupt_acknowledge_strobe_oe <= 1'b0;
    end else begin
      memory_read_strobe_oe           <= mem_oe;
      memory_write_strobe_oe          <= mem_oe;
      early_memory_write_strobe_oe    <= mem_oe;
      io_read_strobe_oe               <= io_oe;
      io_write_strobe_oe              <= io_oe;
      early_io_write_strobe_oe        <= io_oe;
      interrupt_acknowledge_strobe_oe <= io_oe;
    end
  end

  // Latch strobe and transceiver controls
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      address_latch_strobe            <= 1'b0;
      transceiver_enable              <= 1'b0;
      transfer_direction              <= 1'b0;
      cascade_or_peripheral_enable    <= 1'b0;
    end else begin
      // latch strobe every cycle, halt too
      address_latch_strobe            <= (state_next == ST_ADDR);
      transceiver_enable              <= den_next;
      transfer_direction              <= (state_next != ST_IDLE) & write_cycle;
      if (io_mode_reg) begin
        // shared pin as peripheral enable, active low
        cascade_or_peripheral_enable  <= ~peripheral_data_enable_next;
      end else begin
        cascade_or_peripheral_enable  <= mce_next;
      end
    end
  end

  // APB slave, one wait state
  wire apb_access = psel & penable & ~pready;
  // Write lands on the completing edge
  wire apb_done   = psel & penable & pready;
  wire addr_ok    = (paddr == `ADDR_CONTROL) || (paddr == `ADDR_STATUS) || (paddr == `ADDR_CYCLE_COUNT);

  // Register read mux
  reg [31:0] read_word;
  always @* begin
    read_word = 32'h00000000;
    case (paddr)
      `ADDR_CONTROL: begin
        read_word[`CTRL_SOFT_ENABLE] = soft_enable_reg;
      end
      `ADDR_STATUS: begin
        read_word[`STAT_LATCH_LSB+2:`STAT_LATCH_LSB] = halt_latch_reg;
        read_word[`STAT_MODE]      = io_mode_reg;
        read_word[`STAT_GATE_OPEN] = arb_open;
        read_word[`STAT_HALTED]    = (halt_latch_reg == `STATUS_HALT);
        read_word[`STAT_CMD_LSB+`CMD_WIDTH-1:`STAT_CMD_LSB] = ~{interrupt_acknowledge_strobe_n,
          early_io_write_strobe_n, early_memory_write_strobe_n, io_write_strobe_n,
          io_read_strobe_n, memory_write_strobe_n, memory_read_strobe_n};
      end
      `ADDR_CYCLE_COUNT: begin
        read_word[15:0] = cycle_count_reg;
      end
      default: begin
        read_word = 32'h00000000;
      end
    endcase
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready          <= 1'b0;
      pslverr         <= 1'b0;
      prdata          <= 32'h00000000;
      soft_enable_reg <= `CTRL_RESET;
    end else begin
      pready  <= apb_access;
      pslverr <= apb_access & ~addr_ok;
      prdata  <= (apb_access & ~pwrite) ? read_word : 32'h00000000;
      if (apb_done && pwrite && paddr == `ADDR_CONTROL) begin
        soft_enable_reg <= pwdata[`CTRL_SOFT_ENABLE];
      end
    end
  end
endmodule
`default_nettype wire

// ---- tb/cmd_ctrl_sva.sv ----
// Checker for the bus command controller, bound to its top module.
// Assumes status pins reach the strobes three edges later.
`timescale 1ns/1ps
`default_nettype none
module cmd_ctrl_sva (
  input wire logic       pclk,
  input wire logic       presetn,
  input wire logic [2:0] processor_status_inputs,
  input wire logic [2:0] processor_status_driven,
  input wire logic       arbitration_enable_n,
  input wire logic       command_qualifier,
  input wire logic       bus_mode_strap,
  input wire logic       memory_read_strobe_n,
  input wire logic       memory_read_strobe_oe,
  input wire logic       memory_write_strobe_n,
  input wire logic       early_memory_write_strobe_n,
  input wire logic       io_read_strobe_n,
  input wire logic       io_read_strobe_oe,
  input wire logic       io_write_strobe_n,
  input wire logic       early_io_write_strobe_n,
  input wire logic       interrupt_acknowledge_strobe_n,
  input wire logic       address_latch_strobe,
  input wire logic       transceiver_enable,
  input wire logic       transfer_direction,
  input wire logic       cascade_or_peripheral_enable
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire  [2:0] eff = processor_status_inputs | ~processor_status_driven;
  wire  [6:0] cmd = {interrupt_acknowledge_strobe_n, early_io_write_strobe_n, early_memory_write_strobe_n,
                     io_write_strobe_n, io_read_strobe_n, memory_write_strobe_n, memory_read_strobe_n};
  logic [7:0] aen_low_cnt;
  // Cycles the grant has been held low
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn) aen_low_cnt <= 8'h00;
    else if (arbitration_enable_n) aen_low_cnt <= 8'h00;
    else if (aen_low_cnt != 8'hff) aen_low_cnt <= aen_low_cnt + 8'h01;
  AST_PASSIVE_RELEASE: assert property ((eff == 3'h7) [*4] |-> &cmd && !transceiver_enable)
    else $error("strobe held while bus passive");
  AST_QUALIFIER_OFF: assert property (!command_qualifier [*4] |-> &cmd && !transceiver_enable)
    else $error("command active while qualifier low");
  AST_LATCH_PULSE: assert property (address_latch_strobe |=> !address_latch_strobe)
    else $error("latch strobe wider than one cycle");
  AST_WRITE_DIR: assert property (!memory_write_strobe_n || !io_write_strobe_n |-> transfer_direction)
    else $error("direction low during write");
  AST_ARB_FLOAT: assert property (arbitration_enable_n [*4] |-> !memory_read_strobe_oe)
    else $error("memory driver on without grant");
  AST_IO_MODE_OE: assert property (bus_mode_strap [*8] |-> io_read_strobe_oe)
    else $error("io driver off in io mode");
  AST_GRANT_DELAY: assert property ((!memory_read_strobe_n || (!io_read_strobe_n && !bus_mode_strap))
    && !arbitration_enable_n |-> aen_low_cnt >= 8'h0b)
    else $error("command before enable delay");
  AST_CASCADE: assert property (cascade_or_peripheral_enable && !bus_mode_strap |->
    address_latch_strobe && $past(eff, 3) == 3'h0)
    else $error("cascade enable outside acknowledge");
  AST_INTERRUPT_ACKNOWLEDGE_STROBE_CODE: assert property (!interrupt_acknowledge_strobe_n |-> $past(eff, 3) == 3'h0)
    else $error("acknowledge on wrong code");
  AST_IO_READ_CODE: assert property (!io_read_strobe_n |-> $past(eff, 3) == 3'h1)
    else $error("io read on wrong code");
  AST_MEM_READ_CODE: assert property (!memory_read_strobe_n |-> $past(eff, 3) inside {3'h4, 3'h5})
    else $error("memory read on wrong code");
  AST_MEM_WRITE_CODE: assert property (!memory_write_strobe_n || !early_memory_write_strobe_n
    |-> $past(eff, 3) == 3'h6)
    else $error("memory write on wrong code");
  AST_EARLY_FIRST: assert property ($fell(io_write_strobe_n) |-> $past(!early_io_write_strobe_n))
    else $error("early io write not ahead");
endmodule
bind cpu_bus_command_controller cmd_ctrl_sva cmd_ctrl_sva_inst (.pclk, .presetn, .processor_status_inputs,
  .processor_status_driven, .arbitration_enable_n, .command_qualifier, .bus_mode_strap, .memory_read_strobe_n,
  .memory_read_strobe_oe, .memory_write_strobe_n, .early_memory_write_strobe_n, .io_read_strobe_n,
  .io_read_strobe_oe, .io_write_strobe_n, .early_io_write_strobe_n, .interrupt_acknowledge_strobe_n,
  .address_latch_strobe, .transceiver_enable, .transfer_direction, .cascade_or_peripheral_enable);
`default_nettype wire

// ---- tb/cpu_status_model.sv ----
// Processor status lines and bus arbiter facing the controller.
// Assumes tasks are entered just after a rising edge.
`timescale 1ns/1ps
`default_nettype none
module cpu_status_model (
  input  wire logic       pclk,
  output var  logic [2:0] processor_status_inputs,
  output var  logic [2:0] processor_status_driven,
  output var  logic       arbitration_enable_n
);
  initial begin
    processor_status_inputs = 3'h0;
    processor_status_driven = 3'h0;
    arbitration_enable_n    = 1'b1;
  end
  task automatic bus_cycle(input logic [2:0] code, input int len, input logic [2:0] drv);
    processor_status_inputs <= code;
    processor_status_driven <= drv;
    repeat (len) @(posedge pclk);
    processor_status_inputs <= 3'h7;
    processor_status_driven <= 3'h7;
    repeat (5) @(posedge pclk);
  endtask
  // grant driven at once, whatever the bus is doing
  task automatic grant(input logic on);
    arbitration_enable_n <= !on;
    @(posedge pclk);
  endtask
endmodule
`default_nettype wire

// ---- tb/testbench.sv ----
// Self-checking bench for the bus command controller.
// Assumes the status model sits on the status and grant pins.
`timescale 1ns/1ps
`default_nettype none
`include "bus_cmd_consts.vh"
`define CHK(nm, e, g) begin cmp_count++; if ((g) !== (e)) begin num_errors++; \
  $display("CHECK FAILED %s expected %0h seen %0h", nm, e, g); end end
module testbench;
  logic pclk = 0, presetn = 0, command_qualifier = 1, bus_mode_strap = 0;
  logic psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, rd;
  logic er, den_seen, dir_seen, cas_seen, pde_seen;
  logic [6:0] seen;
  logic [7:0] ale_cnt;
  int num_errors = 0, cmp_count = 0, cycles = 0;
  wire [2:0] processor_status_inputs, processor_status_driven;
  wire arbitration_enable_n, address_latch_strobe, transceiver_enable, transfer_direction;
  wire memory_read_strobe_n, memory_write_strobe_n, early_memory_write_strobe_n, io_read_strobe_n;
  wire io_write_strobe_n, early_io_write_strobe_n, interrupt_acknowledge_strobe_n, cascade_or_peripheral_enable;
  wire memory_read_strobe_oe, memory_write_strobe_oe, early_memory_write_strobe_oe, io_read_strobe_oe;
  wire io_write_strobe_oe, early_io_write_strobe_oe, interrupt_acknowledge_strobe_oe, pready, pslverr;
  wire [31:0] prdata;
  wire [6:0] cmd = {interrupt_acknowledge_strobe_n, early_io_write_strobe_n, early_memory_write_strobe_n,
                    io_write_strobe_n, io_read_strobe_n, memory_write_strobe_n, memory_read_strobe_n};
  wire [6:0] oes = {interrupt_acknowledge_strobe_oe, early_io_write_strobe_oe, early_memory_write_strobe_oe,
                    io_write_strobe_oe, io_read_strobe_oe, memory_write_strobe_oe, memory_read_strobe_oe};
  cpu_status_model cpu_status_model_inst (.pclk, .processor_status_inputs, .processor_status_driven,
    .arbitration_enable_n);
  cpu_bus_command_controller cpu_bus_command_controller_inst (.pclk, .presetn, .processor_status_inputs,
    .processor_status_driven, .arbitration_enable_n, .command_qualifier, .bus_mode_strap, .memory_read_strobe_n,
    .memory_read_strobe_oe, .memory_write_strobe_n, .memory_write_strobe_oe, .early_memory_write_strobe_n,
    .early_memory_write_strobe_oe, .io_read_strobe_n, .io_read_strobe_oe, .io_write_strobe_n, .io_write_strobe_oe,
    .early_io_write_strobe_n, .early_io_write_strobe_oe, .interrupt_acknowledge_strobe_n,
    .interrupt_acknowledge_strobe_oe, .address_latch_strobe, .transceiver_enable, .transfer_direction,
    .cascade_or_peripheral_enable, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr);
  always #5 pclk = ~pclk;
  always @(posedge pclk) begin
    cycles++;
    if (cycles == 20000) begin
      num_errors++;
      results();
    end
  end
  function automatic logic [6:0] exp_cmd(input int c);
    case (c)
      0: exp_cmd = 7'h1 << `CMD_INTERRUPT_ACKNOWLEDGE_STROBE;
      1: exp_cmd = 7'h1 << `CMD_IO_READ;
      2: exp_cmd = (7'h1 << `CMD_IO_WRITE) | (7'h1 << `CMD_EARLY_IO_WRITE);
      4, 5: exp_cmd = 7'h1 << `CMD_MEM_READ;
      6: exp_cmd = (7'h1 << `CMD_MEM_WRITE) | (7'h1 << `CMD_EARLY_MEM_WRITE);
      default: exp_cmd = 7'h00;
    endcase
  endfunction
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
    psel <= 1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 0;
    penable <= 0;
    @(posedge pclk);
  endtask
  task automatic run(input int c, input int len, input logic [2:0] drv);
    {seen, den_seen, dir_seen, cas_seen, pde_seen, ale_cnt} = 0;
    fork
      cpu_status_model_inst.bus_cycle(c[2:0], len, drv);
      repeat (len + 5) begin
        @(posedge pclk);
        seen |= ~cmd;
        ale_cnt += address_latch_strobe;
        den_seen |= transceiver_enable;
        dir_seen |= transfer_direction;
        cas_seen |= cascade_or_peripheral_enable;
        pde_seen |= !cascade_or_peripheral_enable;
      end
    join
    `CHK("idle", 7'h7f, cmd)
  endtask
  task automatic do_reset(input logic strap);
    presetn <= 0;
    bus_mode_strap <= strap;
    repeat (10) @(posedge pclk);
    presetn <= 1;
    repeat (6) @(posedge pclk);
  endtask
  task automatic t_system;
    do_reset(0);
    apb(0, `ADDR_CONTROL, 0);
    `CHK("ctrl", 32'h1, rd)
    cpu_status_model_inst.grant(1);
    repeat (14) @(posedge pclk);
    run(0, 6, 3'h0);
    `CHK("float", 7'h00, seen)
    `CHK("float ale", 0, ale_cnt)
    for (int c = 0; c < 8; c++) begin
      run(c, 6, 3'h7);
      `CHK("cmd", exp_cmd(c), seen)
      `CHK("ale", c != 7, ale_cnt)
      `CHK("dir", c == 2 || c == 6, dir_seen)
      `CHK("den", c != 3 && c != 7, den_seen)
      `CHK("cascade", c == 0, cas_seen)
    end
    apb(0, `ADDR_CYCLE_COUNT, 0);
    `CHK("cycles", 32'h7, rd)
    apb(0, `ADDR_STATUS, 0);
    `CHK("latched", 32'h16, rd & 32'h1f)
    run(0, 6, 3'h7); // first acknowledge of a pair, its cascade pulse not checked
    run(0, 6, 3'h7);
    `CHK("second cascade", 1'b1, cas_seen)
  endtask
  task automatic t_gating;
    command_qualifier <= 0;
    repeat (4) @(posedge pclk);
    run(5, 6, 3'h7);
    `CHK("cen cmd", 7'h00, seen)
    `CHK("cen den", 1'b0, den_seen)
    `CHK("cen oe", 1'b1, memory_read_strobe_oe)
    `CHK("cen oes", 7'h7f, oes)
    command_qualifier <= 1;
    apb(1, `ADDR_CONTROL, 0);
    run(1, 6, 3'h7);
    `CHK("soft", 7'h00, seen)
    apb(1, `ADDR_CONTROL, 1);
    apb(1, `ADDR_STATUS, 0);
    `CHK("ro err", 1'b0, er)
    apb(0, 12'hffc, 0);
    `CHK("unmapped", 1'b1, er)
    cpu_status_model_inst.grant(0);
    repeat (4) @(posedge pclk);
    run(5, 6, 3'h7);
    `CHK("no grant", 7'h00, seen)
    `CHK("float oe", 1'b0, memory_read_strobe_oe)
    `CHK("float oes", 7'h00, oes)
    cpu_status_model_inst.grant(1);
    run(5, 20, 3'h7);
    `CHK("late grant", exp_cmd(5), seen)
  endtask
  task automatic t_io_mode;
    do_reset(1);
    cpu_status_model_inst.grant(0);
    run(1, 6, 3'h7);
    `CHK("io rd", exp_cmd(1), seen)
    `CHK("peripheral_data_enable", 1'b1, pde_seen)
    `CHK("io den", 1'b0, den_seen)
    run(2, 6, 3'h7);
    `CHK("io wr", exp_cmd(2), seen)
    `CHK("io dir", 1'b1, dir_seen)
    run(5, 6, 3'h7);
    `CHK("io mem", 7'h00, seen)
    `CHK("io oes", 7'h6c, oes)
  endtask
  task automatic results;
    $display("comparisons %0d mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  initial begin
    @(posedge pclk);
    t_system();
    t_gating();
    t_io_mode();
    results();
  end
endmodule
`default_nettype wire
